// File: common/ext_port_pkg.sv
// Notes on behaviour
// - Every external access drives its 24-bit address on the address pins.
// - The 32 data pins serve memory data, parallel input, flag I/O or pulse-width output as selected.
// - After reset no data pin is driven; each pin's mode comes from pin_mode_i, which reset does not set.
// - With parallel acquisition selected, channel zero samples words from data bits 31 down to 8.
// - While acknowledge is low the current non-SDRAM access is held and does not complete; SDRAM commands ignore acknowledge.
// - The read strobe is low for reads of external memory and only for those.
// - The write strobe is low for writes to external memory.
// - Each SDRAM operation is encoded on row strobe, column strobe and store strobe together.
// - The addressed bank's chip select goes low during a non-SDRAM access; all selects stay high when idle and for SDRAM commands.
package ext_port_pkg;
  localparam int addr_width = 24;
  localparam int data_width = 32;
  localparam int bank_count = 2;
  localparam int acq_lsb = 8;
  localparam int acq_width = 24;
  localparam int flag_count = 4;
  localparam int setup_ns = 10;
  localparam int setup_cycles = (setup_ns + 9) / 10;
  localparam logic [23:0] addr_reset = 24'h000000;
  localparam logic [1:0] pin_mode_mem = 2'h0;
  localparam logic [1:0] pin_mode_acq = 2'h1;
  localparam logic [1:0] pin_mode_flag = 2'h2;
  localparam logic [1:0] pin_mode_pwm = 2'h3;
  // SDRAM commands as {row, column, store}, active low
  localparam logic [2:0] sd_cmd_nop = 3'h7;
  localparam logic [2:0] sd_cmd_activate = 3'h3;
  localparam logic [2:0] sd_cmd_read = 3'h5;
  localparam logic [2:0] sd_cmd_write = 3'h4;
  localparam logic [2:0] sd_cmd_precharge = 3'h2;
  localparam logic [2:0] sd_cmd_refresh = 3'h1;
  localparam logic [2:0] sd_cmd_mode = 3'h0;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_setup = 2'b01,
    st_strobe = 2'b11,
    st_done = 2'b10
  } access_state_type;
endpackage

// File: common/pin_mux_if.sv
`timescale 1ns/1ps
interface pin_mux_if;
  logic [31:0] mode_sel;
  logic [31:0] pin_in;
  logic [31:0] flag_out;
  logic [31:0] pwm_out;
  logic acq_en;
  logic [23:0] acq_word;
  logic acq_valid;
  modport mux(input mode_sel, pin_in, flag_out, pwm_out, acq_en, output acq_word, acq_valid);
  modport core(output mode_sel, pin_in, flag_out, pwm_out, acq_en, input acq_word, acq_valid);
endinterface

// File: design/ext_mem_port.sv
`timescale 1ns/1ps
module ext_mem_port #(
  parameter int unsigned wait_min = 2
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Core request
  input wire logic req_i,
  input wire logic req_write_i,
  input wire logic req_sdram_i,
  input wire logic [2:0] req_sd_cmd_i,
  input wire logic [0:0] req_bank_i,
  input wire logic [23:0] req_addr_i,
  input wire logic [31:0] req_wdata_i,
  output logic busy_o,
  output logic done_o,
  output logic [31:0] rdata_o,
  // Pin function control
  input wire logic [63:0] pin_mode_i,
  input wire logic acq_sel_i,
  input wire logic [31:0] flag_out_i,
  input wire logic [31:0] flag_oe_i,
  input wire logic [31:0] pwm_out_i,
  output logic [23:0] acq_word_o,
  output logic acq_valid_o,
  output logic [31:0] flag_in_o,
  // External pins
  output logic [23:0] addr_o,
  input wire logic [31:0] data_i,
  output logic [31:0] data_o,
  output logic [31:0] data_oe_o,
  input wire logic ack_i,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [1:0] bank_chip_select_n_o,
  output logic row_strobe_n_o,
  output logic column_strobe_n_o,
  output logic sdram_store_strobe_n_o
);
  typedef struct packed {
    ext_port_pkg::access_state_type st;
    logic [7:0] cnt;
    logic write;
    logic sdram;
    logic [31:0] wdata;
    logic [23:0] addr;
    logic [31:0] data_out;
    logic [31:0] data_oe;
    logic [31:0] rdata;
    logic rd_n;
    logic wr_n;
    logic [1:0] cs_n;
    logic [2:0] sd_cmd;
    logic done;
    logic busy;
    logic [31:0] flag_in;
  } port_type;
  port_type r;
  port_type next_r;
  pin_mux_if mx();

  function automatic logic [1:0] mode_of(input logic [63:0] m, input int i);
    mode_of = m[2*i +: 2];
  endfunction

  assign mx.pin_in = data_i;
  assign mx.flag_out = flag_out_i;
  assign mx.pwm_out = pwm_out_i;
  assign mx.acq_en = acq_sel_i;
  assign mx.mode_sel = '0;

  acq_sampler u_acq (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .mx(mx)
  );

  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    // Pin function per data bit
    for (int i = 0; i < 32; i++) begin
      case (mode_of(pin_mode_i, i))
        ext_port_pkg::pin_mode_flag: begin
          next_r.data_out[i] = flag_out_i[i];
          next_r.data_oe[i] = flag_oe_i[i];
          next_r.flag_in[i] = data_i[i];
        end
        ext_port_pkg::pin_mode_pwm: begin
          next_r.data_out[i] = pwm_out_i[i];
          next_r.data_oe[i] = 1'b1;
        end
        ext_port_pkg::pin_mode_acq: begin
          next_r.data_oe[i] = 1'b0;
        end
        default: begin
          next_r.data_out[i] = r.wdata[i];
          next_r.data_oe[i] = (r.st != ext_port_pkg::st_idle) && r.write && !r.sdram;
        end
      endcase
    end
    case (r.st)
      ext_port_pkg::st_idle: begin
        next_r.rd_n = 1'b1;
        next_r.wr_n = 1'b1;
        next_r.cs_n = 2'h3;
        next_r.sd_cmd = ext_port_pkg::sd_cmd_nop;
        if (req_i) begin
          next_r.addr = req_addr_i;
          next_r.write = req_write_i;
          next_r.sdram = req_sdram_i;
          next_r.wdata = req_wdata_i;
          next_r.cnt = 8'(ext_port_pkg::setup_cycles);
          if (req_sdram_i) begin
            next_r.sd_cmd = req_sd_cmd_i;
            next_r.st = ext_port_pkg::st_done;
            next_r.done = 1'b1;
          end else begin
            next_r.cs_n = ~(2'h1 << req_bank_i);
            next_r.st = ext_port_pkg::st_setup;
          end
        end
      end
      ext_port_pkg::st_setup: begin
        if (r.cnt <= 8'h01) begin
          next_r.rd_n = r.write;
          next_r.wr_n = !r.write;
          next_r.cnt = 8'(wait_min);
          next_r.st = ext_port_pkg::st_strobe;
        end else begin
          next_r.cnt = r.cnt - 8'h01;
        end
      end
      ext_port_pkg::st_strobe: begin
        if (r.cnt > 8'h01) begin
          next_r.cnt = r.cnt - 8'h01;
        end else if (ack_i) begin
          if (!r.write) begin
            next_r.rdata = data_i;
          end
          next_r.rd_n = 1'b1;
          next_r.wr_n = 1'b1;
          next_r.cs_n = 2'h3;
          next_r.done = 1'b1;
          next_r.st = ext_port_pkg::st_done;
        end
      end
      ext_port_pkg::st_done: begin
        next_r.sd_cmd = ext_port_pkg::sd_cmd_nop;
        next_r.cs_n = 2'h3;
        next_r.st = ext_port_pkg::st_idle;
      end
      default: begin
        next_r.st = ext_port_pkg::st_idle;
      end
    endcase
    next_r.busy = next_r.st != ext_port_pkg::st_idle;
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      r <= '0;
      r.addr <= ext_port_pkg::addr_reset;
      r.rd_n <= 1'b1;
      r.wr_n <= 1'b1;
      r.cs_n <= 2'h3;
      r.sd_cmd <= ext_port_pkg::sd_cmd_nop;
      r.st <= ext_port_pkg::st_idle;
    end else begin
      r <= next_r;
    end
  end

  assign busy_o = r.busy;
  assign done_o = r.done;
  assign rdata_o = r.rdata;
  assign addr_o = r.addr;
  assign data_o = r.data_out;
  assign data_oe_o = r.data_oe;
  assign rd_n_o = r.rd_n;
  assign wr_n_o = r.wr_n;
  assign bank_chip_select_n_o = r.cs_n;
  assign row_strobe_n_o = r.sd_cmd[2];
  assign column_strobe_n_o = r.sd_cmd[1];
  assign sdram_store_strobe_n_o = r.sd_cmd[0];
  assign acq_word_o = mx.acq_word;
  assign acq_valid_o = mx.acq_valid;
  assign flag_in_o = r.flag_in;

  property p_ack_hold;
    @(posedge clk_sys_i) disable iff (srst_i)
      (r.st == ext_port_pkg::st_strobe && !ack_i) |=> !done_o;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("access completed with ack low");
  property p_rd_only_read;
    @(posedge clk_sys_i) disable iff (srst_i) !rd_n_o |-> (!r.write && bank_chip_select_n_o != 2'h3);
  endproperty
  a_rd_only_read: assert property (p_rd_only_read) else $error("read strobe outside a read");
  property p_wr_write;
    @(posedge clk_sys_i) disable iff (srst_i)
      (r.st == ext_port_pkg::st_setup && r.write && r.cnt <= 8'h01) |=> !wr_n_o;
  endproperty
  a_wr_write: assert property (p_wr_write) else $error("write strobe missing");
  property p_idle_cs;
    @(posedge clk_sys_i) disable iff (srst_i) (r.st == ext_port_pkg::st_idle) |-> bank_chip_select_n_o == 2'h3;
  endproperty
  a_idle_cs: assert property (p_idle_cs) else $error("chip select active while idle");
  property p_bank_sel;
    @(posedge clk_sys_i) disable iff (srst_i)
      (r.st == ext_port_pkg::st_idle && req_i && !req_sdram_i) |=> !bank_chip_select_n_o[$past(req_bank_i)];
  endproperty
  a_bank_sel: assert property (p_bank_sel) else $error("wrong bank selected");
  property p_addr;
    @(posedge clk_sys_i) disable iff (srst_i)
      (r.st == ext_port_pkg::st_idle && req_i) |=> addr_o == $past(req_addr_i);
  endproperty
  a_addr: assert property (p_addr) else $error("address not driven");
  property p_sd_cmd;
    @(posedge clk_sys_i) disable iff (srst_i)
      (r.st == ext_port_pkg::st_idle && req_i && req_sdram_i) |=>
        {row_strobe_n_o, column_strobe_n_o, sdram_store_strobe_n_o} == $past(req_sd_cmd_i) ##1
        {row_strobe_n_o, column_strobe_n_o, sdram_store_strobe_n_o} == 3'h7;
  endproperty
  a_sd_cmd: assert property (p_sd_cmd) else $error("sdram command not encoded");
  property p_reset_strobes;
    @(posedge clk_sys_i) disable iff (srst_i)
      $past(srst_i) |-> (rd_n_o && wr_n_o && row_strobe_n_o && column_strobe_n_o && sdram_store_strobe_n_o &&
        bank_chip_select_n_o == 2'h3);
  endproperty
  a_reset_strobes: assert property (p_reset_strobes) else $error("strobe active after reset");
  property p_reset_mode;
    @(posedge clk_sys_i) disable iff (srst_i) $past(srst_i) |-> data_oe_o == 32'h00000000;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("data pins driven after reset");
  c_read: cover property (@(posedge clk_sys_i) done_o && !r.write && !r.sdram);
  c_write: cover property (@(posedge clk_sys_i) done_o && r.write);
  c_wait: cover property (@(posedge clk_sys_i) (r.st == ext_port_pkg::st_strobe && !ack_i) [*3]);
endmodule // ext_mem_port

// File: design/parallel_acquisition_port_sampler.sv
`timescale 1ns/1ps
module acq_sampler (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Pin mux side
  pin_mux_if.mux mx
);
  typedef struct packed {
    logic [23:0] word;
    logic valid;
  } samp_type;
  samp_type r;
  samp_type next_r;

  always_comb begin
    next_r = r;
    next_r.valid = 1'b0;
    if (mx.acq_en) begin
      next_r.word = mx.pin_in[31:ext_port_pkg::acq_lsb];
      next_r.valid = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign mx.acq_word = r.word;
  assign mx.acq_valid = r.valid;

  property p_acq_sample;
    @(posedge clk_sys_i) disable iff (srst_i)
      mx.acq_en |=> (mx.acq_valid && mx.acq_word == $past(mx.pin_in[31:8]));
  endproperty
  a_acq_sample: assert property (p_acq_sample) else $error("parallel word not sampled");
  c_acq: cover property (@(posedge clk_sys_i) mx.acq_valid);
endmodule // acq_sampler

// File: test/ext_mem_model.sv
`timescale 1ns/1ps
module ext_mem_model (
  // Clock
  input wire logic clk_sys_i,
  // Device pins
  input wire logic [23:0] addr_i,
  input wire logic [31:0] dout_i,
  input wire logic [31:0] doe_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [1:0] cs_n_i,
  // Bench control
  input wire logic [3:0] waits_i,
  input wire logic [31:0] park_i,
  // Resolved pins
  output logic [31:0] wire_o,
  output logic ack_o
);
  logic [31:0] mem [16];
  logic [3:0] cnt;
  logic strobe;
  assign strobe = !(rd_n_i && wr_n_i) && cs_n_i != 2'h3;
  // Holds ack low for the first waits_i strobe cycles
  assign ack_o = !(strobe && cnt < waits_i);
  // Undriven pins carry memory data during a read strobe, otherwise the pull-up or bench level
  assign wire_o = (doe_i & dout_i) | (~doe_i & ((strobe && !rd_n_i) ? mem[addr_i[3:0]] : park_i));
  always @(posedge clk_sys_i) begin
    cnt <= strobe ? cnt + 4'h1 : 4'h0;
    if (strobe && !wr_n_i) begin
      mem[addr_i[3:0]] <= wire_o;
    end
  end
endmodule // ext_mem_model

// File: test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic req_i = 1'b0, req_write_i = 1'b0, req_sdram_i = 1'b0, req_bank_i = 1'b0, acq_sel_i = 1'b0;
  logic [2:0] req_sd_cmd_i = 3'h7;
  logic [23:0] req_addr_i = 24'h0;
  logic [31:0] req_wdata_i = 32'h0, flag_out_i = 32'h0, flag_oe_i = 32'h0, pwm_out_i = 32'h0;
  logic [31:0] park = 32'hffffffff;
  logic [63:0] pin_mode_i = 64'h0;
  logic [3:0] waits = 4'h0;
  logic busy_o, done_o, acq_valid_o, ack_i, rd_n_o, wr_n_o;
  logic row_strobe_n_o, column_strobe_n_o, sdram_store_strobe_n_o;
  logic [31:0] rdata_o, flag_in_o, data_i, data_o, data_oe_o;
  logic [23:0] acq_word_o, addr_o;
  logic [1:0] bank_chip_select_n_o;
  int miscompares = 0;
  int cmp_count = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  ext_mem_port i_ext_mem_port (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .req_i(req_i), .req_write_i(req_write_i),
    .req_sdram_i(req_sdram_i), .req_sd_cmd_i(req_sd_cmd_i), .req_bank_i(req_bank_i), .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i), .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o), .pin_mode_i(pin_mode_i),
    .acq_sel_i(acq_sel_i), .flag_out_i(flag_out_i), .flag_oe_i(flag_oe_i), .pwm_out_i(pwm_out_i),
    .acq_word_o(acq_word_o), .acq_valid_o(acq_valid_o), .flag_in_o(flag_in_o), .addr_o(addr_o),
    .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o), .ack_i(ack_i), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o),
    .bank_chip_select_n_o(bank_chip_select_n_o), .row_strobe_n_o(row_strobe_n_o),
    .column_strobe_n_o(column_strobe_n_o), .sdram_store_strobe_n_o(sdram_store_strobe_n_o));
  ext_mem_model i_ext_mem_model (.clk_sys_i(clk_sys_i), .addr_i(addr_o), .dout_i(data_o), .doe_i(data_oe_o),
    .rd_n_i(rd_n_o), .wr_n_i(wr_n_o), .cs_n_i(bank_chip_select_n_o), .waits_i(waits), .park_i(park),
    .wire_o(data_i), .ack_o(ack_i));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic idle_pins();
    check({rd_n_o, wr_n_o, row_strobe_n_o, column_strobe_n_o, sdram_store_strobe_n_o}, 5'h1f);
    check(bank_chip_select_n_o, 2'h3);
    check(busy_o, 1'b0);
  endtask
  task automatic test_reset();
    tick(3);
    idle_pins();
    tick(3);
    srst_i = 1'b0;
    tick(2);
    idle_pins();
    check(addr_o, 24'h0);
    check(data_oe_o, 32'h0);
    $display("test_reset done");
  endtask
  task automatic access(input logic wr, input logic bank, input logic [23:0] a, input logic [31:0] d);
    int lat, rd_cnt, wr_cnt;
    lat = 0;
    rd_cnt = 0;
    wr_cnt = 0;
    req_write_i = wr;
    req_bank_i = bank;
    req_addr_i = a;
    req_wdata_i = d;
    req_sdram_i = 1'b0;
    req_i = 1'b1;
    tick(1);
    req_i = 1'b0;
    while (done_o !== 1'b1 && lat < 40) begin
      check(addr_o, a);
      check(bank_chip_select_n_o, bank ? 2'h1 : 2'h2);
      check(busy_o, 1'b1);
      rd_cnt += !rd_n_o;
      wr_cnt += !wr_n_o;
      tick(1);
      lat++;
    end
    check(lat, 1 + ((waits > 1) ? waits + 1 : 2));
    check(rd_cnt, wr ? 0 : lat - 1);
    check(wr_cnt, wr ? lat - 1 : 0);
    if (!wr) check(rdata_o, d);
    tick(3);
    idle_pins();
  endtask
  task automatic test_async();
    for (int w = 0; w < 7; w += 3) begin
      waits = w[3:0];
      access(1'b1, w[0], 24'hab0000 + 24'(w), 32'h5a5a0000 ^ 32'(w));
      access(1'b0, w[0], 24'hab0000 + 24'(w), 32'h5a5a0000 ^ 32'(w));
    end
    $display("test_async done");
  endtask
  task automatic test_sdram();
    logic [2:0] cmds [6];
    cmds = '{ext_port_pkg::sd_cmd_activate, ext_port_pkg::sd_cmd_read, ext_port_pkg::sd_cmd_write,
      ext_port_pkg::sd_cmd_precharge, ext_port_pkg::sd_cmd_refresh, ext_port_pkg::sd_cmd_mode};
    foreach (cmds[k]) begin
      req_sdram_i = 1'b1;
      req_sd_cmd_i = cmds[k];
      req_i = 1'b1;
      tick(1);
      req_i = 1'b0;
      check(done_o, 1'b1);
      check({row_strobe_n_o, column_strobe_n_o, sdram_store_strobe_n_o}, cmds[k]);
      check({rd_n_o, wr_n_o}, 2'h3);
      tick(3);
      idle_pins();
    end
    req_sdram_i = 1'b0;
    $display("test_sdram done");
  endtask
  task automatic test_pins();
    park = 32'hc3a59600;
    pin_mode_i = {{24{ext_port_pkg::pin_mode_acq}}, 6'h0, ext_port_pkg::pin_mode_pwm, {4{ext_port_pkg::pin_mode_flag}}};
    acq_sel_i = 1'b1;
    flag_out_i = 32'h5;
    flag_oe_i = 32'h3;
    pwm_out_i = 32'h10;
    tick(3);
    check(acq_word_o, park[31:8]);
    check(acq_valid_o, 1'b1);
    check(data_oe_o[4:0], 5'h13);
    check(data_o[4:0], 5'h15);
    check(flag_in_o[3:0], 4'h1);
    $display("test_pins done");
  endtask
  task automatic stop_test();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #100us;
    miscompares++;
    stop_test();
  end
  initial begin
    test_reset();
    test_async();
    test_sdram();
    test_pins();
    stop_test();
  end
endmodule // tb_top
